// ### eeprom_pkg.sv
// Shared constants and state types for both ends of the two-wire EEPROM link.
// Assumes both ends import it whole and share one reference clock rate.
package eeprom_pkg;
    localparam int PAGE_COUNT = 128;
    localparam int PAGE_BYTES = 32;
    localparam int MEM_BYTES = PAGE_COUNT * PAGE_BYTES;
    localparam int ADDR_W = 12;
    localparam int OFS_W = 5;
    localparam int PAGE_W = ADDR_W - OFS_W;
    localparam int ID_MSB = 7;
    localparam int ID_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int RW_BIT = 0;
    localparam int WA_HI_MSB = 3;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // Device type code; the value is arbitrary.
    localparam logic [3:0] DEV_TYPE_ID = 4'h5;
    // Write cycle length in reference clock cycles; must be at least PAGE_BYTES.
    localparam int WRITE_CYCLE_TIME = 1000;
    localparam int TMR_W = 16;
    // Reference cycles per quarter of a host-made serial clock period.
    localparam int SCL_QTR = 5;
    localparam int QTR_W = 4;
    typedef enum logic [2:0] {L_IDLE, L_DEV, L_WA_HI, L_WA_LO, L_DATA, L_IGNORE} link_state_t;
    typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;
endpackage : eeprom_pkg

// ### two_wire_if.sv
// Two-wire link between the host end and the EEPROM end.
// Assumes open-drain data: any enabled driver pulls the line low, else the pull-up wins.
`timescale 1ns/1ps
interface two_wire_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface : two_wire_if

// ### eeprom_dev_end.sv
// EEPROM end: address decode, acknowledge, page buffer and self-timed write.
// Assumes the serial clock comes from the host and stands still between frames.
`timescale 1ns/1ps

module eeprom_dev_end
    import eeprom_pkg::*;
#(
    parameter int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME
)
(
    // Link
    two_wire_if.dev bus,
    // Reference clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Straps; left open they read as zero
    input wire logic i_chip_select_pin0 = 1'b0,
    input wire logic i_chip_select_pin1 = 1'b0,
    input wire logic i_chip_select_pin2 = 1'b0,
    input wire logic i_write_protect = 1'b0,
    // Array read-back
    input wire logic [ADDR_W-1:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    // Status
    output logic o_busy,
    output logic o_standby
);
    link_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shreg_q;
    logic sda_rise_q;
    logic stop_tgl_q;
    logic stop_mark_q;
    logic stop_open;
    logic ack_q;
    logic [ADDR_W-1:0] wptr_q;
    logic armed_q;
    logic [PAGE_BYTES-1:0] mask_q;
    logic [7:0] page_buf_q [PAGE_BYTES];
    logic [2:0] cs_meta_q;
    logic [2:0] cs_q;
    logic busy_meta_q;
    logic busy_link_q;
    logic start_seen;
    logic byte_done;
    logic accept;
    logic [7:0] rx_byte;

    logic [3:0] ref_meta_q;
    logic [3:0] ref_sync_q;
    logic scl_p_q;
    logic sda_p_q;
    logic busy_q;
    logic [TMR_W-1:0] timer_q;
    logic [OFS_W:0] idx_q;
    logic [PAGE_BYTES-1:0] mask_snap_q;
    logic [PAGE_W-1:0] page_q;
    logic standby_q;
    logic [7:0] mem [MEM_BYTES];
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic armed_s;
    logic stop_det;
    logic start_det;
    logic begin_wr;
    logic wr_end;

    // Data is captured on the rising serial edge; the falling edge compares against it.
    always_ff @(posedge bus.scl or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sda_rise_q <= 1'b1;
            stop_mark_q <= 1'b0;
        end
        else
        begin
            sda_rise_q <= bus.sda;
            stop_mark_q <= stop_tgl_q;
        end
    end

    // A Stop raises data after the rising clock edge sampled it low, so the next Start would be missed.
    // The Stop toggles a flag on the data edge; the next rising clock edge catches up with it.
    always_ff @(posedge bus.sda or negedge i_rst_n)
    begin
        if (!i_rst_n)
            stop_tgl_q <= 1'b0;
        else if (bus.scl)
            stop_tgl_q <= ~stop_tgl_q;
    end

    // A Start is seen at the falling edge that follows it: data fell while the clock was high.
    assign stop_open = stop_tgl_q ^ stop_mark_q;
    assign start_seen = (sda_rise_q | stop_open) & ~bus.sda;
    assign rx_byte = {shreg_q[6:0], sda_rise_q};
    assign byte_done = (state_q != L_IDLE) && (state_q != L_IGNORE) && (cnt_q == LAST_BIT) && !start_seen;

    always_comb
    begin
        accept = 1'b0;
        unique case (state_q)
            L_DEV:
                accept = (rx_byte[ID_MSB:ID_LSB] == DEV_TYPE_ID)
                    && (rx_byte[SEL_MSB:SEL_LSB] == cs_q)
                    && !busy_link_q;
            L_WA_HI, L_WA_LO, L_DATA:
                accept = 1'b1;
            L_IDLE, L_IGNORE:
                accept = 1'b0;
        endcase
    end

    // Straps and the write-cycle flag cross into the link domain through two stages.
    always_ff @(negedge bus.scl or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cs_meta_q <= 3'h0;
            cs_q <= 3'h0;
            busy_meta_q <= 1'b0;
            busy_link_q <= 1'b0;
        end
        else
        begin
            cs_meta_q <= {i_chip_select_pin2, i_chip_select_pin1, i_chip_select_pin0};
            cs_q <= cs_meta_q;
            busy_meta_q <= busy_q;
            busy_link_q <= busy_meta_q;
        end
    end

    always_ff @(negedge bus.scl or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= L_IDLE;
            cnt_q <= 4'h0;
            shreg_q <= 8'h00;
        end
        else if (start_seen)
        begin
            state_q <= L_DEV;
            cnt_q <= 4'h0;
        end
        else if (state_q != L_IDLE && state_q != L_IGNORE)
        begin
            if (cnt_q == ACK_SLOT)
                cnt_q <= 4'h0;
            else
            begin
                shreg_q <= rx_byte;
                cnt_q <= cnt_q + 4'h1;
            end
            if (byte_done)
            begin
                unique case (state_q)
                    L_DEV:
                        state_q <= (accept && !rx_byte[RW_BIT]) ? L_WA_HI : L_IGNORE;
                    L_WA_HI:
                        state_q <= L_WA_LO;
                    L_WA_LO:
                        state_q <= L_DATA;
                    L_DATA:
                        state_q <= L_DATA;
                    L_IDLE, L_IGNORE:
                        state_q <= state_q;
                endcase
            end
        end
    end

    // The acknowledge is held for exactly one serial period, then the line is released.
    always_ff @(negedge bus.scl or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ack_q <= 1'b0;
        else
            ack_q <= byte_done && accept;
    end

    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = ack_q;

    always_ff @(negedge bus.scl or negedge i_rst_n)
    begin
        if (!i_rst_n)
            wptr_q <= '0;
        else if (byte_done && state_q == L_WA_HI)
            wptr_q[ADDR_W-1:8] <= rx_byte[WA_HI_MSB:0];
        else if (byte_done && state_q == L_WA_LO)
            wptr_q[7:0] <= rx_byte;
        else if (byte_done && state_q == L_DATA)
            wptr_q[OFS_W-1:0] <= wptr_q[OFS_W-1:0] + 5'h01;
    end

    always_ff @(negedge bus.scl or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mask_q <= '0;
            armed_q <= 1'b0;
        end
        else if (start_seen)
        begin
            mask_q <= '0;
            armed_q <= 1'b0;
        end
        else if (byte_done && state_q == L_DATA)
        begin
            mask_q[wptr_q[OFS_W-1:0]] <= 1'b1;
            armed_q <= 1'b1;
        end
    end

    always_ff @(negedge bus.scl)
    begin
        if (byte_done && state_q == L_DATA)
            page_buf_q[wptr_q[OFS_W-1:0]] <= rx_byte;
    end

    // Reference domain: bus conditions, protect pin and the armed flag, two stages each.
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ref_meta_q <= 4'hC;
            ref_sync_q <= 4'hC;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            ref_meta_q <= {bus.scl, bus.sda, i_write_protect, armed_q};
            ref_sync_q <= ref_meta_q;
            scl_p_q <= ref_sync_q[3];
            sda_p_q <= ref_sync_q[2];
        end
    end

    assign scl_s = ref_sync_q[3];
    assign sda_s = ref_sync_q[2];
    assign wp_s = ref_sync_q[1];
    assign armed_s = ref_sync_q[0];
    assign stop_det = scl_s && scl_p_q && sda_s && !sda_p_q;
    assign start_det = scl_s && scl_p_q && !sda_s && sda_p_q;
    // Protect is looked at only here, so a later change cannot touch a running cycle.
    assign begin_wr = stop_det && armed_s && !busy_q && !wp_s;
    assign wr_end = busy_q && (timer_q == 16'h0001);

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            busy_q <= 1'b0;
            timer_q <= '0;
        end
        else if (begin_wr)
        begin
            busy_q <= 1'b1;
            timer_q <= TMR_W'(WRITE_CYCLE_CYCLES);
        end
        else if (busy_q)
        begin
            busy_q <= !wr_end;
            timer_q <= timer_q - 16'h0001;
        end
    end

    // The page buffer is read only while the host is refused, so it cannot change underneath.
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            idx_q <= '0;
            mask_snap_q <= '0;
            page_q <= '0;
        end
        else if (begin_wr)
        begin
            idx_q <= '0;
            mask_snap_q <= mask_q;
            page_q <= wptr_q[ADDR_W-1:OFS_W];
        end
        else if (busy_q && !idx_q[OFS_W])
            idx_q <= idx_q + 6'h01;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (busy_q && !idx_q[OFS_W] && mask_snap_q[idx_q[OFS_W-1:0]])
            mem[{page_q, idx_q[OFS_W-1:0]}] <= page_buf_q[idx_q[OFS_W-1:0]];
        o_rd_data <= mem[i_rd_addr];
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            standby_q <= 1'b1;
        // Link activity during a write cycle is ignored, so only the cycle's end may restore standby.
        else if (start_det && !busy_q)
            standby_q <= 1'b0;
        else if ((stop_det && !begin_wr && !busy_q) || wr_end)
            standby_q <= 1'b1;
    end

    assign o_busy = busy_q;
    assign o_standby = standby_q;
endmodule : eeprom_dev_end

// ### eeprom_host_end.sv
// Host end: makes the serial clock and sends address, word address and data bytes.
// Assumes one reference clock; reads beyond the address byte are not carried out.
`timescale 1ns/1ps
module eeprom_host_end
    import eeprom_pkg::*;
#(
    parameter bit NO_CS_PINS = 1'b0
)
(
    // Link
    two_wire_if.host bus,
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Command
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic [2:0] i_cmd_sel,
    input wire logic i_cmd_read,
    input wire logic [ADDR_W-1:0] i_cmd_addr,
    input wire logic [5:0] i_cmd_len,
    // Write data
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [7:0] i_wr_data,
    // Status
    output logic o_done,
    output logic o_nack
);
    host_state_t state_q;
    logic [QTR_W-1:0] qcnt_q;
    logic [1:0] phase_q;
    logic [3:0] bitn_q;
    logic [7:0] tx_q;
    logic [1:0] seq_q;
    logic [5:0] left_q;
    logic [ADDR_W-1:0] addr_q;
    logic scl_q;
    logic low_q;
    logic ack_hi_q;
    logic done_q;
    logic nack_q;
    logic sda_meta_q;
    logic sda_s_q;
    logic tick;
    logic ack_end;
    logic need_data;
    logic stall;
    logic take_cmd;
    logic [5:0] room;
    logic [5:0] len_eff;

    assign tick = (qcnt_q == QTR_W'(SCL_QTR - 1));
    assign take_cmd = i_cmd_valid && o_cmd_ready;
    assign o_cmd_ready = (state_q == H_IDLE);
    // Clip so a write never runs past the page end and wraps over earlier bytes.
    assign room = 6'h20 - {1'b0, i_cmd_addr[OFS_W-1:0]};
    assign len_eff = (i_cmd_len > room) ? room : i_cmd_len;
    assign ack_end = (state_q == H_BIT) && (phase_q == 2'h3) && (bitn_q == ACK_SLOT);
    assign need_data = ack_end && !ack_hi_q && (left_q != 6'h00) && (seq_q == 2'h2);
    assign stall = need_data && !i_wr_valid;
    assign o_wr_ready = tick && need_data;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sda_meta_q <= 1'b1;
            sda_s_q <= 1'b1;
        end
        else
        begin
            sda_meta_q <= bus.sda;
            sda_s_q <= sda_meta_q;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            qcnt_q <= '0;
        else
            qcnt_q <= tick ? '0 : qcnt_q + 4'h1;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            phase_q <= 2'h0;
        else if (state_q == H_IDLE)
            phase_q <= 2'h0;
        else if (tick && !stall)
            phase_q <= phase_q + 2'h1;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= H_IDLE;
            bitn_q <= 4'h0;
            tx_q <= 8'h00;
            seq_q <= 2'h0;
            left_q <= 6'h00;
            addr_q <= '0;
        end
        else if (take_cmd)
        begin
            state_q <= H_START;
            bitn_q <= 4'h0;
            tx_q <= {DEV_TYPE_ID, NO_CS_PINS ? 3'h0 : i_cmd_sel, i_cmd_read};
            seq_q <= 2'h0;
            left_q <= i_cmd_read ? 6'h00 : len_eff + 6'h02;
            addr_q <= i_cmd_addr;
        end
        else if (tick && !stall && phase_q == 2'h3)
        begin
            unique case (state_q)
                H_START:
                    state_q <= H_BIT;
                H_BIT:
                    if (bitn_q != ACK_SLOT)
                    begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        bitn_q <= bitn_q + 4'h1;
                    end
                    else if (ack_hi_q || left_q == 6'h00)
                        state_q <= H_STOP;
                    else
                    begin
                        bitn_q <= 4'h0;
                        left_q <= left_q - 6'h01;
                        unique case (seq_q)
                            2'h0: tx_q <= {4'h0, addr_q[ADDR_W-1:8]};
                            2'h1: tx_q <= addr_q[7:0];
                            default: tx_q <= i_wr_data;
                        endcase
                        seq_q <= (seq_q == 2'h2) ? seq_q : seq_q + 2'h1;
                    end
                H_STOP:
                    state_q <= H_IDLE;
                H_IDLE:
                    state_q <= H_IDLE;
            endcase
        end
    end

    // Pin drive per quarter of a data bit: set data, raise clock, hold, drop clock; Start and Stop use their own steps.
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_q <= 1'b1;
            low_q <= 1'b0;
        end
        else if (tick && !stall)
        begin
            unique case (state_q)
                H_START:
                    if (phase_q == 2'h1)
                        low_q <= 1'b1;
                    else if (phase_q == 2'h2)
                        scl_q <= 1'b0;
                H_BIT:
                    if (phase_q == 2'h0)
                        low_q <= (bitn_q != ACK_SLOT) && !tx_q[7];
                    else if (phase_q == 2'h1)
                        scl_q <= 1'b1;
                    else if (phase_q == 2'h3)
                        scl_q <= 1'b0;
                H_STOP:
                    if (phase_q == 2'h0)
                        low_q <= 1'b1;
                    else if (phase_q == 2'h1)
                        scl_q <= 1'b1;
                    else if (phase_q == 2'h2)
                        low_q <= 1'b0;
                H_IDLE:
                begin
                    scl_q <= 1'b1;
                    low_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ack_hi_q <= 1'b0;
        else if (tick && state_q == H_BIT && phase_q == 2'h2 && bitn_q == ACK_SLOT)
            ack_hi_q <= sda_s_q;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            done_q <= 1'b0;
            nack_q <= 1'b0;
        end
        else
        begin
            done_q <= tick && state_q == H_STOP && phase_q == 2'h3;
            if (take_cmd)
                nack_q <= 1'b0;
            else if (tick && ack_end && ack_hi_q)
                nack_q <= 1'b1;
        end
    end

    assign bus.scl = scl_q;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = low_q;
    assign o_done = done_q;
    assign o_nack = nack_q;
endmodule : eeprom_host_end

// ### eeprom_link_monitor.sv
// Concurrent checks on the two-wire link between the host end and the EEPROM end.
// Assumes it sits beside the link interface and samples on the reference clock.
`timescale 1ns/1ps
module eeprom_link_monitor
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Link
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence start_cond;
        scl && $fell(sda);
    endsequence
    sequence stop_cond;
        scl && $rose(sda);
    endsequence

    start_scl_a: assert property (start_cond |-> scl[*4] ##[1:8] !scl)
        else $error("serial clock did not fall after a start");
    stop_idle_a: assert property (stop_cond |-> (scl && sda)[*8])
        else $error("link not idle after a stop");
    ack_hold_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8] ##[1:400] !dev_sda_oe)
        else $error("device acknowledge has the wrong length");
    dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data changed while serial clock high");
    ack_owner_a: assert property (dev_sda_oe && scl |-> !host_sda_oe && !sda)
        else $error("acknowledge slot not owned by the device");
    dev_drive_a: assert property (dev_sda_oe |-> !dev_sda_o)
        else $error("device drives data high");
    host_drive_a: assert property (host_sda_oe |-> !host_sda_o && !sda)
        else $error("host drives data high");
    scl_high_a: assert property ($rose(scl) |-> scl[*8])
        else $error("serial clock high phase too short");
    scl_low_a: assert property ($fell(scl) |-> (!scl)[*8])
        else $error("serial clock low phase too short");
endmodule : eeprom_link_monitor

// ### serial_eeprom_addr_write_ctrl_bench.sv
// Self-checking bench joining the host end and the EEPROM end over one link.
// Assumes both ends share the reference clock; the host makes the serial clock.
`timescale 1ns/1ps
`define CMP(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR at %0t: got %h expected %h", $time, got, exp); end end
module serial_eeprom_addr_write_ctrl_bench
    import eeprom_pkg::*;
;
    // Long enough that two refused polls fit inside one write cycle.
    localparam int WC = 800;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b1;
    logic [2:0] cs_pins = 3'h5;
    logic wp = 1'b0;
    logic [11:0] rd_addr = 12'h000;
    logic [7:0] rd_data;
    logic busy, standby, cmd_ready, wr_ready, done, nack;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_sel = 3'h0;
    logic cmd_read = 1'b0;
    logic [11:0] cmd_addr = 12'h000;
    logic [5:0] cmd_len = 6'h00;
    logic wr_valid = 1'b0;
    logic [7:0] wr_data = 8'h00;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    always #2 i_ref_clk = ~i_ref_clk;

    two_wire_if link();
    eeprom_host_end i_eeprom_host_end (.bus(link), .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_sel(cmd_sel), .i_cmd_read(cmd_read),
        .i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len), .i_wr_valid(wr_valid), .o_wr_ready(wr_ready),
        .i_wr_data(wr_data), .o_done(done), .o_nack(nack));
    eeprom_dev_end #(.WRITE_CYCLE_CYCLES(WC)) i_eeprom_dev_end (.bus(link), .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n), .i_chip_select_pin0(cs_pins[0]), .i_chip_select_pin1(cs_pins[1]),
        .i_chip_select_pin2(cs_pins[2]), .i_write_protect(wp), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
        .o_busy(busy), .o_standby(standby));
    eeprom_link_monitor i_eeprom_link_monitor (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .scl(link.scl),
        .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

    task finish_test;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // Data bytes count up from d0; the next byte is loaded only after the host took the last.
    task automatic send(input logic [2:0] sel, input logic rd, input logic [11:0] addr,
                        input logic [5:0] len, input logic [7:0] d0);
        int n;
        logic took;
        n = 0;
        took = 1'b0;
        @(negedge i_ref_clk);
        cmd_sel = sel;
        cmd_read = rd;
        cmd_addr = addr;
        cmd_len = len;
        wr_data = d0;
        wr_valid = 1'b1;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        @(negedge i_ref_clk);
        cmd_valid = 1'b0;
        while (done !== 1'b1 && n < 20000)
        begin
            if (took)
                wr_data = wr_data + 8'h01;
            took = wr_ready;
            @(negedge i_ref_clk);
            n++;
        end
        `CMP(done, 1'b1)
        wr_valid = 1'b0;
    endtask : send

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < WC + 100)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        @(negedge i_ref_clk);
        `CMP(standby, 1'b1)
    endtask : wait_idle

    task automatic read_chk(input logic [11:0] a, input logic [7:0] exp);
        @(negedge i_ref_clk);
        rd_addr = a;
        @(negedge i_ref_clk);
        `CMP(rd_data, exp)
    endtask : read_chk

    task automatic test_byte_write;
        send(3'h5, 1'b0, 12'h123, 6'h01, 8'hA5);
        `CMP(nack, 1'b0)
        `CMP(busy, 1'b1)
        wait_idle();
        read_chk(12'h123, 8'hA5);
        $display("byte write test done");
    endtask : test_byte_write

    task automatic test_page_write;
        send(3'h5, 1'b0, 12'h7E0, 6'h01, 8'h11);
        wait_idle();
        send(3'h5, 1'b0, 12'h7FC, 6'h04, 8'h40);
        wait_idle();
        read_chk(12'h7FC, 8'h40);
        read_chk(12'h7FF, 8'h43);
        read_chk(12'h7E0, 8'h11);
        send(3'h5, 1'b0, 12'h020, 6'h20, 8'h80);
        `CMP(nack, 1'b0)
        wait_idle();
        read_chk(12'h020, 8'h80);
        read_chk(12'h03F, 8'h9F);
        $display("page write test done");
    endtask : test_page_write

    task automatic test_polling;
        send(3'h5, 1'b0, 12'h200, 6'h01, 8'h66);
        send(3'h5, 1'b0, 12'h200, 6'h01, 8'h77);
        `CMP(nack, 1'b1)
        `CMP(standby, 1'b0)
        send(3'h5, 1'b1, 12'h000, 6'h00, 8'h00);
        `CMP(nack, 1'b1)
        wait_idle();
        send(3'h5, 1'b1, 12'h000, 6'h00, 8'h00);
        `CMP(nack, 1'b0)
        read_chk(12'h200, 8'h66);
        $display("polling test done");
    endtask : test_polling

    task automatic test_select;
        send(3'h2, 1'b0, 12'h300, 6'h01, 8'h55);
        `CMP(nack, 1'b1)
        `CMP(busy, 1'b0)
        cs_pins = 3'h2;
        send(3'h2, 1'b0, 12'h300, 6'h00, 8'h00);
        `CMP(nack, 1'b0)
        `CMP(busy, 1'b0)
        wait_idle();
        cs_pins = 3'h5;
        $display("select test done");
    endtask : test_select

    task automatic test_protect;
        wp = 1'b1;
        send(3'h5, 1'b0, 12'h123, 6'h02, 8'hE0);
        `CMP(nack, 1'b0)
        `CMP(busy, 1'b0)
        wait_idle();
        read_chk(12'h123, 8'hA5);
        wp = 1'b0;
        send(3'h5, 1'b0, 12'h124, 6'h01, 8'hC4);
        wp = 1'b1;
        `CMP(busy, 1'b1)
        wait_idle();
        read_chk(12'h124, 8'hC4);
        wp = 1'b0;
        $display("protect test done");
    endtask : test_protect

    initial
    begin
        // A real falling edge is needed so that the link-side flops, clocked by the idle link, reset too.
        #1;
        i_rst_n = 1'b0;
        repeat (16) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        test_byte_write();
        test_page_write();
        test_polling();
        test_select();
        test_protect();
        finish_test();
    end
endmodule : serial_eeprom_addr_write_ctrl_bench
